// file: design/pcih_map.vh
// Register map, field positions and reset values of the configuration header block.
`ifndef PCIH_MAP_VH
`define PCIH_MAP_VH
`define PCIH_ADDR_W 8
`define PCIH_OFF_CAT_LINE 8'h08
`define PCIH_OFF_LINE_HOLD 8'h0c
`define PCIH_OFF_WIN0 8'h10
`define PCIH_OFF_WIN5 8'h24
`define PCIH_WIN_STRIDE 8'h04
`define PCIH_OFF_HOLD_COUNT 8'h40
`define PCIH_CAT_RESET 24'hff0000
`define PCIH_LINE_RESET 8'h00
`define PCIH_HOLD_RESET 8'h00
`define PCIH_LAYOUT_KIND 8'h00
`define PCIH_HOLD_WMASK 8'hf8
`define PCIH_WIN_COUNT 6
`define PCIH_WIN_IO_BIT 0
`define PCIH_WIN_LOC_LSB 1
`define PCIH_WIN_LOC_MSB 2
`define PCIH_WIN_PREF_BIT 3
`define PCIH_LOC_64 2'b10
`define PCIH_PAIR_NONE 2'd0
`define PCIH_PAIR_W1W0 2'd1
`define PCIH_PAIR_W2W1 2'd2
`define PCIH_WIN_ADDR_LSB 4
`define PCIH_IO_ADDR_LSB 2
`endif

// file: design/pcih_window.v
// One base address window register with build-time size and type.
`timescale 1ns/1ps
`include "pcih_map.vh"
module pcih_window #(
	parameter [31:0] WINDOW_BUILD_PARAMETER = 32'h00000000,
	parameter IMPLEMENTED = 0,
	parameter UPPER_HALF = 0
) (
	input wire pclk,
	input wire presetn,
	input wire wr_en,
	input wire [31:0] wr_data,
	input wire [3:0] wr_strb,
	output wire [31:0] rd_value
);
	// Fixed low bits come from the build parameter; an upper half has none of its own.
	localparam IS_IO = (UPPER_HALF == 0) && WINDOW_BUILD_PARAMETER[`PCIH_WIN_IO_BIT];
	localparam integer ADDR_LSB = IS_IO ? `PCIH_IO_ADDR_LSB :
		(UPPER_HALF != 0 ? 0 : `PCIH_WIN_ADDR_LSB);
	localparam [31:0] LSB_MASK = ~((32'h00000001 << ADDR_LSB) - 32'h00000001);
	localparam [31:0] WMASK = (IMPLEMENTED != 0) ? (WINDOW_BUILD_PARAMETER & LSB_MASK) :
		32'h00000000;
	localparam [31:0] FIXED = (IMPLEMENTED != 0 && UPPER_HALF == 0) ?
		(WINDOW_BUILD_PARAMETER & ~LSB_MASK) : 32'h00000000;
	reg [31:0] base;
	wire [31:0] lane_mask;
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : lane
			assign lane_mask[g*8+7:g*8] = {8{wr_strb[g]}};
		end
	endgenerate
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base <= 32'h00000000;
		end else if (wr_en) begin
			base <= (base & ~(WMASK & lane_mask)) | (wr_data & WMASK & lane_mask);
		end
	end
	assign rd_value = (base & WMASK) | FIXED;
endmodule

// file: design/pcih_config_regs.v
// Configuration header registers behind an APB slave, with bus-hold countdown.
`timescale 1ns/1ps
`include "pcih_map.vh"
//////////////////////////////////////////////////////////////////////////////
// How it works
// - Read-only 24-bit category, reset value ff0000.
// - Category holds base, sub-category, programming interface.
// - Writable line size drives local-side output.
// - Line size, hold budget only when master-capable.
// - Hold budget: bits 2..0 zero, 7..3 writable.
// - Hold budget bounds master bus ownership time.
// - Working copy decrements each clock of bus ownership once started.
// - Hold budget reads zero after reset.
// - Layout kind reads 00, single function.
// - Up to six contiguous windows, at least one.
// - Window bit 0: memory 0, I/O 1.
// - Memory bits 2..1 give 32/64-bit location.
// - Memory bit 3 reports prefetchable.
// - Writable upper bits from parameter; low bits read fixed from parameter.
// - One 64-bit window on pair 1/0 or 2/1.
// - Lower register low half, higher one high.
module pcih_config_regs #(
	parameter [23:0] CATEGORY_CODE = `PCIH_CAT_RESET,
	parameter MASTER_CAPABLE = 1,
	parameter WINDOW_COUNT = 1,
	parameter [1:0] WIDE_PAIR = `PCIH_PAIR_NONE,
	parameter [31:0] WINDOW_BUILD_PARAMETER0 = 32'hff000000,
	parameter [31:0] WINDOW_BUILD_PARAMETER1 = 32'h00000000,
	parameter [31:0] WINDOW_BUILD_PARAMETER2 = 32'h00000000,
	parameter [31:0] WINDOW_BUILD_PARAMETER3 = 32'h00000000,
	parameter [31:0] WINDOW_BUILD_PARAMETER4 = 32'h00000000,
	parameter [31:0] WINDOW_BUILD_PARAMETER5 = 32'h00000000
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire master_start,
	input wire master_active,
	output reg [7:0] line_size_words_out,
	output reg hold_expired
);
	//////////////////////////////////////////////////////////////////////////
	// Build-time settings are sanitised here so that a bad choice falls back to a legal layout.
	localparam LINE_PRESENT = (MASTER_CAPABLE != 0);
	localparam integer WIN_USED = (WINDOW_COUNT < 1) ? 1 :
		((WINDOW_COUNT > `PCIH_WIN_COUNT) ? `PCIH_WIN_COUNT : WINDOW_COUNT);
	localparam [31:0] LOWER_PARAM = (WIDE_PAIR == `PCIH_PAIR_W2W1) ?
		WINDOW_BUILD_PARAMETER1 : WINDOW_BUILD_PARAMETER0;
	localparam [1:0] LOWER_LOC = LOWER_PARAM[`PCIH_WIN_LOC_MSB:`PCIH_WIN_LOC_LSB];
	localparam PAIR_ROOM = (WIDE_PAIR == `PCIH_PAIR_W2W1) ? (WIN_USED > 2) : (WIN_USED > 1);
	// A pair is honoured only if its lower half is a memory window set for 64-bit space.
	localparam PAIR_OK = (WIDE_PAIR == `PCIH_PAIR_W1W0 || WIDE_PAIR == `PCIH_PAIR_W2W1) &&
		!LOWER_PARAM[`PCIH_WIN_IO_BIT] && (LOWER_LOC == `PCIH_LOC_64) && PAIR_ROOM;
	localparam [1:0] PAIR_USED = PAIR_OK ? WIDE_PAIR : `PCIH_PAIR_NONE;

	function [31:0] window_param;
		input integer idx;
		begin
			case (idx)
				0: window_param = WINDOW_BUILD_PARAMETER0;
				1: window_param = WINDOW_BUILD_PARAMETER1;
				2: window_param = WINDOW_BUILD_PARAMETER2;
				3: window_param = WINDOW_BUILD_PARAMETER3;
				4: window_param = WINDOW_BUILD_PARAMETER4;
				default: window_param = WINDOW_BUILD_PARAMETER5;
			endcase
		end
	endfunction

	function is_upper;
		input integer idx;
		begin
			is_upper = (PAIR_USED == `PCIH_PAIR_W1W0 && idx == 1) ||
				(PAIR_USED == `PCIH_PAIR_W2W1 && idx == 2);
		end
	endfunction

	// Decodes one register word; anything above the header's byte range misses.
	function reg_hit;
		input [31:0] addr;
		input [7:0] offset;
		begin
			reg_hit = (addr[31:`PCIH_ADDR_W] == 24'h000000) &&
				({addr[`PCIH_ADDR_W-1:2], 2'b00} == offset);
		end
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// APB decode: access phase with one wait state; unmapped reads zero, no error.
	wire access = psel && penable && !pready;
	wire wr_access = access && pwrite;

	reg [7:0] line_size;
	reg [7:0] hold_budget;
	reg [7:0] hold_count;
	wire [31:0] win_rd [0:5];
	wire [5:0] win_hit;

	genvar n;
	generate
		for (n = 0; n < `PCIH_WIN_COUNT; n = n + 1) begin : win
			// Contiguous from window 0: index below count is present.
			localparam PRESENT = (n < WIN_USED);
			localparam [31:0] WIN_OFF = `PCIH_OFF_WIN0 + `PCIH_WIN_STRIDE * n;
			assign win_hit[n] = reg_hit(paddr, WIN_OFF[`PCIH_ADDR_W-1:0]);
			pcih_window #(
				.WINDOW_BUILD_PARAMETER(window_param(n)),
				.IMPLEMENTED(PRESENT ? 1 : 0),
				.UPPER_HALF(is_upper(n) ? 1 : 0)
			) u_win (
				.pclk(pclk),
				.presetn(presetn),
				.wr_en(wr_access && win_hit[n]),
				.wr_data(pwdata),
				.wr_strb(pstrb),
				.rd_value(win_rd[n])
			);
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////
	// Line size and hold budget.
	wire hit_line_hold = reg_hit(paddr, `PCIH_OFF_LINE_HOLD);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_size <= `PCIH_LINE_RESET;
			hold_budget <= `PCIH_HOLD_RESET;
		end else if (wr_access && hit_line_hold && LINE_PRESENT) begin
			if (pstrb[0]) begin
				line_size <= pwdata[7:0];
			end
			if (pstrb[1]) begin
				hold_budget <= pwdata[15:8] & `PCIH_HOLD_WMASK;
			end
		end
	end

	// Working copy: loaded when a master transaction starts, counts down per clock while master_active is high.
	localparam [1:0] HOLD_IDLE = 2'b00;
	localparam [1:0] HOLD_RUN = 2'b01;
	localparam [1:0] HOLD_OUT = 2'b10;
	reg [1:0] hold_state;
	reg [1:0] next_hold_state;
	reg [7:0] next_hold_count;
	always @* begin
		next_hold_state = hold_state;
		next_hold_count = hold_count;
		if (!LINE_PRESENT) begin
			next_hold_state = HOLD_IDLE;
			next_hold_count = 8'h00;
		end else if (master_start) begin
			next_hold_count = hold_budget;
			if (hold_budget == 8'h00) begin
				next_hold_state = HOLD_OUT;
			end else begin
				next_hold_state = HOLD_RUN;
			end
		end else begin
			case (hold_state)
				HOLD_IDLE: begin
					next_hold_state = HOLD_IDLE;
				end
				HOLD_RUN: begin
					// The count freezes while this function does not own the bus.
					if (master_active && hold_count != 8'h00) begin
						next_hold_count = hold_count - 8'h01;
						if (hold_count == 8'h01) begin
							next_hold_state = HOLD_OUT;
						end
					end
				end
				HOLD_OUT: begin
					if (!master_active) begin
						next_hold_state = HOLD_IDLE;
					end
				end
				default: begin
					next_hold_state = HOLD_IDLE;
				end
			endcase
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_state <= HOLD_IDLE;
			hold_count <= 8'h00;
			hold_expired <= 1'b0;
		end else begin
			hold_state <= next_hold_state;
			hold_count <= next_hold_count;
			hold_expired <= (next_hold_state == HOLD_OUT);
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_size_words_out <= `PCIH_LINE_RESET;
		end else begin
			line_size_words_out <= LINE_PRESENT ? line_size : 8'h00;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Read mux.
	reg [31:0] next_rdata;
	integer k;
	always @* begin
		next_rdata = 32'h00000000;
		if (reg_hit(paddr, `PCIH_OFF_CAT_LINE)) begin
			next_rdata = {CATEGORY_CODE, 8'h00};
		end else if (hit_line_hold) begin
			if (LINE_PRESENT) begin
				next_rdata = {8'h00, `PCIH_LAYOUT_KIND, hold_budget, line_size};
			end else begin
				next_rdata = {8'h00, `PCIH_LAYOUT_KIND, 16'h0000};
			end
		end else if (reg_hit(paddr, `PCIH_OFF_HOLD_COUNT)) begin
			next_rdata = {24'h000000, hold_count};
		end else begin
			for (k = 0; k < `PCIH_WIN_COUNT; k = k + 1) begin
				if (win_hit[k]) begin
					next_rdata = win_rd[k];
				end
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= access;
			pslverr <= 1'b0;
			if (access && !pwrite) begin
				prdata <= next_rdata;
			end
		end
	end
endmodule

// file: verification/pcih_config_regs_props.sv
// Port checks for the configuration header block.
`timescale 1ns/1ps
`include "pcih_map.vh"
module pcih_config_regs_props (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire [7:0] line_size_words_out,
	input wire master_start,
	input wire master_active,
	input wire hold_expired
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire rd = psel && penable && pready && !pwrite;
	a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
	a_ready_answer: assert property (psel && penable && !pready |=> pready) else $error("no answer");
	a_idle_quiet: assert property (!psel |=> !pready) else $error("ready while idle");
	a_no_error: assert property (pready |-> !pslverr) else $error("error answer");
	a_cat_fixed: assert property (rd && paddr[7:0] == 8'h08 |->
		prdata == {`PCIH_CAT_RESET, 8'h00}) else $error("category changed");
	a_hold_low_zero: assert property (rd && paddr[7:0] == 8'h0c |->
		prdata[23:16] == 8'h00 && prdata[10:8] == 3'h0) else $error("fixed bits set");
	a_unmapped_zero: assert property (rd && (paddr[7:0] < 8'h08 || paddr[7:0] > 8'h40) |->
		prdata == 32'h0) else $error("unmapped data");
	a_line_follows: assert property (pready && pwrite && paddr[7:0] == 8'h0c && pstrb[0] |=>
		##1 line_size_words_out == $past(pwdata[7:0], 2)) else $error("line size stale");
	a_expired_idle: assert property (!master_active && !master_start |=> !hold_expired)
		else $error("expired while idle");
endmodule
bind pcih_config_regs pcih_config_regs_props u_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.line_size_words_out(line_size_words_out), .master_start(master_start),
	.master_active(master_active), .hold_expired(hold_expired));

// file: verification/pcih_local_master.sv
// Local-side bus master that sizes its burst by the line size.
`timescale 1ns/1ps
module pcih_local_master (
	input wire pclk,
	input wire presetn,
	input wire go,
	input wire [7:0] line_size,
	output reg master_start,
	output reg master_active
);
	reg [7:0] left;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			master_start <= 1'h0;
			master_active <= 1'h0;
			left <= 8'h00;
		end else begin
			master_start <= go;
			master_active <= left != 8'h00;
			left <= go ? line_size : (left != 8'h00 ? left - 8'h01 : left);
		end
	end
endmodule

// file: verification/pci_config_header_regs_test.sv
// Register access tests for the configuration header block.
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED at %0t: %h not %h", $time, a, e); end end
module pci_config_header_regs_test;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
	logic [31:0] paddr = 0, pwdata = 0, rd;
	logic [3:0] pstrb = 4'hf;
	wire [31:0] prdata;
	wire pready, pslverr, master_start, master_active, hold_expired;
	wire [7:0] line_size_words_out;
	int n_mismatch = 0, n_tests = 0, n;
	logic [7:0] addr [7] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h80};
	logic [31:0] rst_val [7] = '{32'hff000000, 0, 32'hc, 0, 32'h1, 0, 0};
	logic [31:0] wr_val [7] = '{32'hff000000, 32'hf8ff, 32'hfffff00c, 32'hff, 32'hffffff01, 0, 0};
	pcih_config_regs #(.WINDOW_COUNT(3), .WIDE_PAIR(2'h1), .WINDOW_BUILD_PARAMETER0(32'hfffff00c),
		.WINDOW_BUILD_PARAMETER1(32'h000000ff), .WINDOW_BUILD_PARAMETER2(32'hffffff01)) uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .master_start(master_start), .master_active(master_active),
		.line_size_words_out(line_size_words_out), .hold_expired(hold_expired));
	pcih_local_master partner (.pclk(pclk), .presetn(presetn), .go(go),
		.line_size(line_size_words_out), .master_start(master_start),
		.master_active(master_active));
	initial forever #5 pclk = ~pclk;
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 9);
		if (k >= 9) n_mismatch++;
		rd = prdata;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task give_verdict;
		$display("mismatches %0d checks %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		#200000;
		n_mismatch++;
		give_verdict;
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		`CHK(line_size_words_out, 8'h00);
		for (int i = 0; i < 7; i++) begin
			apb(0, addr[i], 0);
			`CHK(rd, rst_val[i]);
			apb(1, addr[i], 32'hffffffff);
			apb(0, addr[i], 0);
			`CHK(rd, wr_val[i]);
		end
		`CHK(line_size_words_out, 8'hff);
		apb(1, 8'h0c, 32'h00001720);
		apb(0, 8'h0c, 0);
		`CHK(rd, 32'h00001020);
		go <= 1;
		@(posedge pclk);
		go <= 0;
		n = 0;
		while (hold_expired !== 1'b1 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		`CHK(n inside {18, 19}, 1'b1);
		apb(0, 8'h40, 0);
		`CHK(rd, 32'h0);
		pstrb <= 4'h2;
		apb(1, 8'h0c, 32'h00003355);
		pstrb <= 4'hf;
		apb(0, 8'h0c, 0);
		`CHK(rd, 32'h00003020);
		presetn <= 0;
		@(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		`CHK(hold_expired, 1'b0);
		`CHK(line_size_words_out, 8'h00);
		apb(0, 8'h0c, 0);
		`CHK(rd, 32'h0);
		give_verdict;
	end
endmodule
